/* File: bench/flash_dev_model.sv */
// Purpose: behavioural flash device on the far side
// Assumes: 256 words; a write stores its data except at LOCKED_WA or with a CMD_RESET low byte
// Notes:   released data lines show the inverse
`timescale 1ns/1ns
module flash_dev_model
	import flash_host_pkg::*;
#(parameter logic [7:0] LOCKED_WA = 8'h20)
(
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic              ceN,
	input wire logic              weN,
	input wire logic              oeN,
	input wire logic              resetN,
	input wire logic [DATA_W-1:0] dqOut,
	output logic     [DATA_W-1:0] dqIn,
	output logic                  ready_busy_n
);
	logic [DATA_W-1:0] mem [256];
	logic [7:0]        wa;
	wire               wrOn = !ceN && !weN && oeN;
	initial foreach (mem[j]) mem[j] = '0;
	always @(posedge wrOn) wa = flashAddr[7:0];
	always @(negedge wrOn)
		if (wa != LOCKED_WA && dqOut[7:0] != CMD_RESET)
			mem[wa] = dqOut;
	always @(ceN, oeN, resetN, flashAddr)
		dqIn = (!ceN && !oeN && resetN) ? mem[flashAddr[7:0]] : ~dqIn;
	initial dqIn = '0;
	initial ready_busy_n = 1'b1;
	always @(resetN)
		if (resetN === 1'b0)
			ready_busy_n = 1'b0;
		else
			ready_busy_n <= #90 1'b1;
endmodule : flash_dev_model

/* File: bench/flash_host_ctrl_assertions.sv */
// Purpose: bus checks on flash_host_ctrl ports
// Assumes: clkEn dropped only while idle
// Notes:   bound after the module
`timescale 1ns/1ns
module flash_host_ctrl_assertions
	import flash_host_pkg::*;
#(parameter int RESET_CYCLES = RESET_PULSE_CYC)
(
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire logic              rspValid,
	input wire logic [DATA_W-1:0] rspData,
	input wire logic              failSeen,
	input wire logic              lockedSector,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic              ceN,
	input wire logic              weN,
	input wire logic              oeN,
	input wire logic              resetN,
	input wire logic [DATA_W-1:0] dqOut,
	input wire logic              dqOe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_wrEn; !weN |-> !ceN && oeN; endproperty
	a_wrEn: assert property (p_wrEn) else $error("bad write");
	property p_noDrv; !oeN |-> dqOe; endproperty
	a_noDrv: assert property (p_noDrv) else $error("bus fight");
	property p_rdLen; $fell(oeN) |-> !oeN[*7]; endproperty
	a_rdLen: assert property (p_rdLen) else $error("short read");
	property p_rstLen; $rose(resetN) |-> !$past(resetN, RESET_CYCLES);
	endproperty
	a_rstLen: assert property (p_rstLen) else $error("short reset");
	property p_wrAddr; !weN |-> $stable(flashAddr) && !dqOe; endproperty
	a_wrAddr: assert property (p_wrAddr) else $error("addr moved");
	property p_wrHold; $rose(weN) |-> !ceN && !dqOe && $stable(dqOut);
	endproperty
	a_wrHold: assert property (p_wrHold) else $error("data hold");
	property p_fail; rspValid |-> failSeen == rspData[FAIL_BIT]; endproperty
	a_fail: assert property (p_fail) else $error("fail flag");
	property p_lock; rspValid |-> lockedSector == (rspData[7:0] == LOCK_SET);
	endproperty
	a_lock: assert property (p_lock) else $error("lock flag");
	c_rd: cover property (rspValid);
	c_wr: cover property ($rose(weN));
	c_rst: cover property ($rose(resetN));
endmodule : flash_host_ctrl_assertions

bind flash_host_ctrl flash_host_ctrl_assertions
	#(.RESET_CYCLES(RESET_CYCLES)) chk_u (.core_clk, .rst_b, .rspValid,
	.rspData, .failSeen, .lockedSector, .flashAddr, .ceN, .weN, .oeN,
	.resetN, .dqOut, .dqOe);

/* File: bench/test_flash_host_ctrl.sv */
// Purpose: self-checking bench for flash_host_ctrl
// Assumes: small reset and recovery counts
// Notes:   clkEn held high except during the frozen check
`timescale 1ns/1ns
module test_flash_host_ctrl
	import flash_host_pkg::*;
;
	logic              core_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              reqValid = 1'b0;
	logic              byteMode = 1'b0;
	logic              clkEn = 1'b1;
	logic              timeoutErr, gotValid, busySeen;
	logic              sawTimeout = 1'b0;
	localparam logic [ADDR_W-1:0] LOCKED_ADDR = 20'h00020;
	hostReq_t          req = '0;
	logic              reqReady, rspValid, failSeen, lockedSector, flashBusy;
	logic              ceN, weN, oeN, resetN, widthSelN, dqOe, ready_busy_n;
	logic [DATA_W-1:0] rspData, dqIn, dqOut;
	logic [ADDR_W-1:0] flashAddr;
	int                n_errors = 0;
	int                comparisons = 0;
	logic [DATA_W-1:0] vals [4] = '{16'h1234, 16'h0001, 16'h0020, 16'h00DF};

	flash_host_ctrl #(.RECOVER_CYCLES(20), .RESET_CYCLES(4)) dut_u (
		.core_clk, .rst_b, .clkEn, .reqValid, .req, .byteMode,
		.reqReady, .rspValid, .rspData, .failSeen, .lockedSector,
		.flashBusy, .timeoutErr, .flashAddr, .ceN, .weN, .oeN, .resetN,
		.widthSelN, .dqIn, .dqOut, .dqOe, .ready_busy_n);
	flash_dev_model #(.LOCKED_WA(LOCKED_ADDR[7:0])) dev_u (.flashAddr,
		.ceN, .weN, .oeN, .resetN, .dqOut, .dqIn, .ready_busy_n);

	// timeout pulse is caught whenever it occurs
	always @(posedge core_clk)
		if (timeoutErr === 1'b1)
			sawTimeout <= 1'b1;

	task automatic stop_test;
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic op(input opKind_t k, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic bm);
		int n;
		req <= '{k, a, d};
		byteMode <= bm;
		reqValid <= 1'b1;
		n = 0;
		do @(posedge core_clk); while (reqReady !== 1'b1 && ++n < 50);
		reqValid <= 1'b0;
		if (n >= 50)
		begin
			n_errors++;
			stop_test();
		end
		gotValid = 1'b0;
		busySeen = 1'b0;
		do
		begin
			@(negedge core_clk);
			gotValid |= (rspValid === 1'b1);
			busySeen |= (flashBusy === 1'b1);
		end
		while (reqReady !== 1'b1 && ++n < 300);
		if (n >= 300)
		begin
			n_errors++;
			stop_test();
		end
		@(posedge core_clk);
	endtask : op

	initial forever #5 core_clk = ~core_clk;

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			op(OP_WRITE, 20'(i + 16), vals[i], i[0]);
			chk("write valid", 16'h0000, 16'(gotValid));
			op(OP_READ, 20'(i + 16), 16'h0000, i[0]);
			chk("read valid", 16'h0001, 16'(gotValid));
			chk("data", vals[i], rspData);
			chk("fail", 16'(vals[i][FAIL_BIT]), 16'(failSeen));
			chk("lock", 16'(vals[i][7:0] == LOCK_SET), 16'(lockedSector));
			chk("width", 16'(!i[0]), 16'(widthSelN));
		end
		clkEn <= 1'b0;
		req <= '{OP_READ, 20'h00011, 16'h0000};
		reqValid <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk("frozen", 16'h0001, 16'(ceN));
		clkEn <= 1'b1;
		reqValid <= 1'b0;
		@(posedge core_clk);
		op(OP_WRITE, 20'h00010, 16'(CMD_RESET), 1'b0);
		op(OP_READ, 20'h00010, 16'h0000, 1'b0);
		chk("after command", vals[0], rspData);
		op(OP_WRITE, LOCKED_ADDR, 16'hAAAA, 1'b0);
		op(OP_READ, LOCKED_ADDR, 16'h0000, 1'b0);
		chk("locked word", 16'h0000, rspData);
		op(OP_HWRESET, 20'h00000, 16'h0000, 1'b0);
		chk("busy seen", 16'h0001, 16'(busySeen));
		chk("busy", 16'h0000, 16'(flashBusy));
		op(OP_READ, 20'h00010, 16'h0000, 1'b0);
		chk("after reset", vals[0], rspData);
		chk("timeout", 16'h0000, 16'(sawTimeout));
		stop_test();
	end
endmodule : test_flash_host_ctrl

/* File: rtl/flash_host_ctrl.sv */
// Purpose: host-side bus master for an asynchronous parallel NOR flash
// Assumes: one request at a time; reqValid sampled when reqReady high
// Notes:   data pins are three signals; oe low means the host drives
`timescale 1ns/1ns
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int RECOVER_CYCLES = RECOVER_CYC,
	parameter int RESET_CYCLES   = RESET_PULSE_CYC
)
(
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic              clkEn,
	input  wire logic              reqValid,
	input  wire hostReq_t          req,
	input  wire logic              byteMode,
	output logic                   reqReady,
	output logic                   rspValid,
	output logic [DATA_W-1:0]      rspData,
	output logic                   failSeen,
	output logic                   lockedSector,
	output logic                   flashBusy,
	output logic                   timeoutErr,
	output logic [ADDR_W-1:0]      flashAddr,
	output logic                   ceN,
	output logic                   weN,
	output logic                   oeN,
	output logic                   resetN,
	output logic                   widthSelN,
	input  wire logic [DATA_W-1:0] dqIn,
	output logic [DATA_W-1:0]      dqOut,
	output logic                   dqOe,
	input  wire logic              ready_busy_n
);

	// refuse counts the sequencer cannot serve
	if (RECOVER_CYCLES < 1 || RESET_CYCLES < 2)
	begin : g_badParams
		$error("flash_host_ctrl: bad timing parameters");
	end

	typedef enum logic [2:0] {
		S_IDLE,
		S_SETUP,
		S_STROBE,
		S_HOLD,
		S_READ,
		S_RSTLOW,
		S_RECOVER
	} state_t;

	localparam int CNT_W = 32;

	state_t            state_q, state_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	hostReq_t          req_q;
	busCtl_t           ctl_q, ctl_d;
	logic [DATA_W-1:0] dqMeta_q, dqSync_q;
	logic [1:0]        rbSync_q;
	logic              rspValid_q, failSeen_q, locked_q, timeout_q;
	logic [DATA_W-1:0] rspData_q;
	logic              dqOe_q, widthSelN_q;
	logic              ready_q, busy_q;

	wire logic cntDone = (cnt_q == '0);
	wire logic devReady = rbSync_q[1];
	wire logic isWrite = (req.kind == OP_WRITE);
	wire logic isHwReset = (req.kind == OP_HWRESET);
	wire logic takeReq = (state_q == S_IDLE) && reqValid;

	always_comb
	begin
		state_d = state_q;
		cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
		ctl_d = ctl_q;
		case (state_q)
			S_IDLE:
			begin
				if (reqValid)
				begin
					if (isHwReset)
					begin
						ctl_d = '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1,
							resetN: 1'b0};
						cnt_d = CNT_W'(RESET_CYCLES - 1);
						state_d = S_RSTLOW;
					end
					else
					begin
						ctl_d.ceN = 1'b0;
						ctl_d.oeN = 1'b1;
						cnt_d = CNT_W'(SETUP_CYC - 1);
						state_d = isWrite ? S_SETUP : S_READ;
						if (!isWrite)
						begin
							ctl_d.oeN = 1'b0;
							cnt_d = CNT_W'(READ_CYC - 1);
						end
					end
				end
			end
			S_SETUP:
				if (cntDone)
				begin
					ctl_d.weN = 1'b0;
					cnt_d = CNT_W'(STROBE_CYC - 1);
					state_d = S_STROBE;
				end
			S_STROBE:
				if (cntDone)
				begin
					ctl_d.weN = 1'b1;
					cnt_d = CNT_W'(HOLD_CYC - 1);
					state_d = S_HOLD;
				end
			S_HOLD:
				if (cntDone)
				begin
					ctl_d.ceN = 1'b1;
					state_d = S_IDLE;
				end
			S_READ:
				if (cntDone)
				begin
					ctl_d.ceN = 1'b1;
					ctl_d.oeN = 1'b1;
					state_d = S_IDLE;
				end
			S_RSTLOW:
				if (cntDone)
				begin
					ctl_d.resetN = 1'b1;
					cnt_d = CNT_W'(RECOVER_CYCLES - 1);
					state_d = S_RECOVER;
				end
			S_RECOVER:
				// wait at most the ready time
				if (devReady || cntDone)
					state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
	end

	// width select low selects byte addressing
	wire logic [ADDR_W-1:0] busAddr = req.addr;
	// failure flag seen on a read
	wire logic readFail = (state_q == S_READ) && cntDone
		&& dqSync_q[FAIL_BIT];
	// lock byte of one marks a protected sector
	wire logic readLock = (state_q == S_READ) && cntDone
		&& (dqSync_q[7:0] == LOCK_SET);
	wire logic recTimeout = (state_q == S_RECOVER) && cntDone
		&& !devReady;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state_q <= S_IDLE;
			cnt_q <= '0;
			ctl_q <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, resetN: 1'b1};
			req_q <= '0;
			dqMeta_q <= '0;
			dqSync_q <= '0;
			rbSync_q <= '0;
			rspValid_q <= 1'b0;
			rspData_q <= '0;
			failSeen_q <= 1'b0;
			locked_q <= 1'b0;
			timeout_q <= 1'b0;
			dqOe_q <= 1'b1;
			widthSelN_q <= 1'b1;
			ready_q <= 1'b1;
			busy_q <= 1'b1;
		end
		else if (clkEn)
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ctl_q <= ctl_d;
			dqMeta_q <= dqIn;
			dqSync_q <= dqMeta_q;
			rbSync_q <= {rbSync_q[0], ready_busy_n};
			busy_q <= !rbSync_q[0];
			ready_q <= (state_d == S_IDLE);
			rspValid_q <= (state_q == S_READ) && cntDone;
			if ((state_q == S_READ) && cntDone)
			begin
				rspData_q <= dqSync_q;
				failSeen_q <= readFail;
				locked_q <= readLock;
			end
			timeout_q <= recTimeout;
			if (takeReq)
			begin
				req_q <= '{kind: req.kind, addr: busAddr,
					data: req.data};
				// low width select for byte mode
				widthSelN_q <= !byteMode;
				// drive data only on write cycles
				dqOe_q <= !isWrite;
			end
			else if (state_q == S_HOLD && cntDone)
				dqOe_q <= 1'b1;
		end
	end

	assign reqReady = ready_q;
	assign rspValid = rspValid_q;
	assign rspData = rspData_q;
	assign failSeen = failSeen_q;
	assign lockedSector = locked_q;
	assign flashBusy = busy_q;
	assign timeoutErr = timeout_q;
	assign flashAddr = req_q.addr;
	assign ceN = ctl_q.ceN;
	assign weN = ctl_q.weN;
	assign oeN = ctl_q.oeN;
	assign resetN = ctl_q.resetN;
	assign widthSelN = widthSelN_q;
	assign dqOut = req_q.data;
	assign dqOe = dqOe_q;

endmodule : flash_host_ctrl

/* File: rtl/flash_host_pkg.sv */
// Function
// - write: strobe and enable low, output-enable high
// - host issues only defined command sequences
// - on failure flag, host sends reset command (controller only reports it on failSeen)
// - leave identification mode with reset command
// - host holds reset pin low beyond minimum
//
// Purpose: constants and types for the parallel flash host controller
// Assumes: 100 MHz core_clk
// Notes:   times in ns, counts derived by rounding as required
package flash_host_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;

	localparam int SETUP_NS = 40;
	localparam int STROBE_NS = 40;
	localparam int HOLD_NS = 20;
	localparam int READ_NS = 70;
	localparam int RESET_PULSE_NS = 500;
	localparam int RECOVER_NS = 20000;

	function automatic int nsToCyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : nsToCyc

	localparam int SETUP_CYC = nsToCyc(SETUP_NS);
	localparam int STROBE_CYC = nsToCyc(STROBE_NS);
	localparam int HOLD_CYC = nsToCyc(HOLD_NS);
	localparam int READ_CYC = nsToCyc(READ_NS);
	localparam int RESET_PULSE_CYC = nsToCyc(RESET_PULSE_NS) + 1;
	localparam int RECOVER_CYC = nsToCyc(RECOVER_NS);

	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] LOCK_SET = 8'h01;
	localparam logic [7:0] LOCK_CLEAR = 8'h00;
	localparam int FAIL_BIT = 5;

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_HWRESET
	} opKind_t;

	typedef struct packed {
		opKind_t             kind;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} hostReq_t;

	typedef struct packed {
		logic                ceN;
		logic                weN;
		logic                oeN;
		logic                resetN;
	} busCtl_t;

endpackage : flash_host_pkg
